// file: sideband_defines.svh
// Widths, command codes and timing counts of the module sideband control
`ifndef SIDEBAND_DEFINES_SVH
`define SIDEBAND_DEFINES_SVH

`define CLK_PERIOD_PS 5000
`define RESET_MIN_NS 1000
`define RESET_MIN_CYC ((`RESET_MIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define MGMT_INIT_NS 2000
`define MGMT_INIT_CYC ((`MGMT_INIT_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`define COUNT_W 16
`define BYTE_W 8
`define BIT_COUNT_W 4
`define BITS_PER_BYTE 4'h8
`define LAST_DATA_BIT 4'h7

`define CMD_LOW_POWER 8'h00
`define CMD_HIGH_POWER 8'h01
`define CMD_CLEAR_INT 8'h02

`define RESET_CMD_VALUE 8'h00

`endif

// file: sideband_pkg.sv
// Types shared by the sideband control modules
`include "sideband_defines.svh"

package sideband_pkg;

   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_INIT = 2'b01,
      ST_LOW_POWER = 2'b10,
      ST_HIGH_POWER = 2'b11
   } power_state_t;

   typedef logic [`BYTE_W-1:0] mgmt_byte_t;

   typedef struct packed {
      logic [`BYTE_W-1:0] shift;
      logic [`BIT_COUNT_W-1:0] bitCount;
      logic [`BYTE_W-1:0] rxByte;
      logic toggle;
      logic ackOe;
      logic sdaLevel;
   } link_state_t;

   typedef struct packed {
      logic resetSync1;
      logic resetSync2;
      logic selSync1;
      logic selSync2;
      logic initSync1;
      logic initSync2;
      logic togSync1;
      logic togSync2;
      logic togSeen;
      logic [`COUNT_W-1:0] rstCount;
      logic [`COUNT_W-1:0] initCount;
      power_state_t state;
      logic swControl;
      logic hpEnable;
      logic dataNotReady;
      logic resetDonePending;
      logic faultPending;
      logic intDrive;
      logic intLevel;
      logic highPower;
      logic lowPower;
      logic presenceN;
      logic [`BYTE_W-1:0] lastCmd;
   } core_state_t;

endpackage

// file: mgmt_link_if.sv
// Carrier between the two-wire byte receiver and the control core
interface mgmt_link_if;
   import sideband_pkg::*;

   mgmt_byte_t rxByte;
   logic rxToggle;

   modport link (
      output rxByte,
      output rxToggle
   );

   modport core (
      input rxByte,
      input rxToggle
   );
endinterface

// file: mgmt_link_rx.sv
// Two-wire byte receiver running on the serial clock
`include "sideband_defines.svh"

module mgmt_link_rx (
   input wire logic sclClk,
   input wire logic linkRstN,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   mgmt_link_if.link linkPort
);
   import sideband_pkg::*;

   link_state_t q_r;
   link_state_t q_nxt;

   always_comb begin
      q_nxt = q_r;
      if (q_r.bitCount < `BITS_PER_BYTE) begin
         q_nxt.shift = {q_r.shift[`BYTE_W-2:0], sdaIn};
         q_nxt.bitCount = q_r.bitCount + 4'h1;
         if (q_r.bitCount == `LAST_DATA_BIT) begin
            // Byte held stable for a whole frame, so the core reads it safely
            q_nxt.rxByte = {q_r.shift[`BYTE_W-2:0], sdaIn};
            q_nxt.toggle = ~q_r.toggle;
            q_nxt.ackOe = 1'b1;
         end
      end else begin
         q_nxt.bitCount = '0;
         q_nxt.ackOe = 1'b0;
      end
   end

   // R1 held in reset while deselected
   always_ff @(posedge sclClk or negedge linkRstN) begin
      if (!linkRstN) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign sdaOut = q_r.sdaLevel;
   assign sdaOe = q_r.ackOe;
   assign linkPort.rxByte = q_r.rxByte;
   assign linkPort.rxToggle = q_r.toggle;
endmodule

// file: module_sideband_control.sv
// Sideband control core of a pluggable optical module: select, reset, init mode, interrupt
//
// Operation
// R1 - Act on bus only while select low
// R2 - Host gives each module own select
// R3 - Long reset pulse restores all defaults
// R4 - Host ignores status until reset-done interrupt
// R5 - Reset done: interrupt with not-ready cleared
// R6 - Power-up raises reset-done interrupt unprompted
// R7 - Init-mode input reads high when undriven
// R8 - Init-mode high software, low hardware control
// R9 - Software mode: low power until enabled
// R10 - Hardware mode: high power after init
// R11 - Host holds init-mode constant while present
// R12 - Presence line held low by module
// R13 - Interrupt low flags fault or critical status
// R14 - Host reads status to find cause
// R15 - Interrupt only pulled low or released
// R16 - Short reset pulses below count ignored
`include "sideband_defines.svh"

module module_sideband_control #(
   parameter int RESET_MIN_CYC = `RESET_MIN_CYC,
   parameter int MGMT_INIT_CYC = `MGMT_INIT_CYC
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic sclClk,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic moduleSelectN,
   input wire logic moduleResetN,
   input wire logic initControlSelect,
   input wire logic faultIn,
   output logic presenceDetectN,
   output logic interruptOutNOut,
   output logic interruptOutNOe,
   output logic highPowerMode,
   output logic lowPowerMode,
   output logic dataNotReady,
   output logic swInitControl,
   output logic resetDoneFlag,
   output logic faultFlag,
   output sideband_pkg::mgmt_byte_t lastCommand
);
   import sideband_pkg::*;

   localparam logic [`COUNT_W-1:0] RESET_LAST = `COUNT_W'(RESET_MIN_CYC - 1);
   localparam logic [`COUNT_W-1:0] RESET_SAT = `COUNT_W'(RESET_MIN_CYC);
   localparam logic [`COUNT_W-1:0] INIT_LAST = `COUNT_W'(MGMT_INIT_CYC - 1);

   core_state_t q_r;
   core_state_t q_nxt;

   logic linkRstN;
   logic rxEvent;
   logic fullReset;
   logic cmdAccepted;
   logic mgmtReady;
   logic clearInt;

   mgmt_link_if linkBus();

   // R1 deselect holds the receiver in reset
   assign linkRstN = resetn & ~moduleSelectN;

   mgmt_link_rx linkRx (
      .sclClk(sclClk),
      .linkRstN(linkRstN),
      .sdaIn(sdaIn),
      .sdaOut(sdaOut),
      .sdaOe(sdaOe),
      .linkPort(linkBus.link)
   );

   always_comb begin
      q_nxt = q_r;

      // Reset, select and init-mode pins pass two flops before the core logic; faultIn is used raw
      q_nxt.resetSync1 = moduleResetN;
      q_nxt.resetSync2 = q_r.resetSync1;
      q_nxt.selSync1 = moduleSelectN;
      q_nxt.selSync2 = q_r.selSync1;
      q_nxt.initSync1 = initControlSelect;
      q_nxt.initSync2 = q_r.initSync1;
      q_nxt.togSync1 = linkBus.rxToggle;
      q_nxt.togSync2 = q_r.togSync1;
      q_nxt.togSeen = q_r.togSync2;

      rxEvent = q_r.togSync2 ^ q_r.togSeen;

      // R16 low pulse must last the full count
      if (!q_r.resetSync2) begin
         if (q_r.rstCount != RESET_SAT) begin
            q_nxt.rstCount = q_r.rstCount + `COUNT_W'(1);
         end
      end else begin
         q_nxt.rstCount = '0;
      end
      // R3 full reset once the count is reached
      fullReset = !q_r.resetSync2 && (q_r.rstCount >= RESET_LAST);

      mgmtReady = (q_r.state == ST_LOW_POWER) || (q_r.state == ST_HIGH_POWER);

      // R1 commands taken only while still selected
      cmdAccepted = rxEvent && !q_r.selSync2 && mgmtReady;
      clearInt = cmdAccepted && (linkBus.rxByte == `CMD_CLEAR_INT);

      if (cmdAccepted) begin
         q_nxt.lastCmd = linkBus.rxByte;
         // R9 software steers the power mode
         if (linkBus.rxByte == `CMD_HIGH_POWER) begin
            q_nxt.hpEnable = 1'b1;
         end else if (linkBus.rxByte == `CMD_LOW_POWER) begin
            q_nxt.hpEnable = 1'b0;
         end
      end

      // Set wins over a clear in the same cycle
      if (clearInt) begin
         q_nxt.resetDonePending = 1'b0;
         q_nxt.faultPending = 1'b0;
      end
      // R13 fault flag latched for the host
      if (faultIn && mgmtReady) begin
         q_nxt.faultPending = 1'b1;
      end

      case (q_r.state)
         ST_RESET: begin
            q_nxt.hpEnable = 1'b0;
            q_nxt.dataNotReady = 1'b1;
            q_nxt.resetDonePending = 1'b0;
            q_nxt.faultPending = 1'b0;
            q_nxt.initCount = '0;
            q_nxt.lastCmd = `RESET_CMD_VALUE;
            if (q_r.resetSync2) begin
               // R8 init mode caught as reset releases
               q_nxt.swControl = q_r.initSync2;
               q_nxt.state = ST_INIT;
            end
         end
         ST_INIT: begin
            if (q_r.initCount == INIT_LAST) begin
               // R5 not-ready cleared with the interrupt
               q_nxt.dataNotReady = 1'b0;
               // R6 reached from power-up as well
               q_nxt.resetDonePending = 1'b1;
               // R10 hardware mode goes straight to high power
               if (q_r.swControl) begin
                  q_nxt.state = ST_LOW_POWER;
               end else begin
                  q_nxt.state = ST_HIGH_POWER;
               end
            end else begin
               q_nxt.initCount = q_r.initCount + `COUNT_W'(1);
            end
         end
         ST_LOW_POWER: begin
            // R9 stays low until software enables
            if (!q_r.swControl || q_nxt.hpEnable) begin
               q_nxt.state = ST_HIGH_POWER;
            end
         end
         ST_HIGH_POWER: begin
            if (q_r.swControl && !q_nxt.hpEnable) begin
               q_nxt.state = ST_LOW_POWER;
            end
         end
         default: begin
            q_nxt.state = ST_RESET;
         end
      endcase

      // R3 settings back to defaults
      if (fullReset) begin
         q_nxt.state = ST_RESET;
         q_nxt.hpEnable = 1'b0;
         q_nxt.dataNotReady = 1'b1;
         q_nxt.resetDonePending = 1'b0;
         q_nxt.faultPending = 1'b0;
         q_nxt.lastCmd = `RESET_CMD_VALUE;
      end

      // R15 pin level fixed low, only the enable moves
      q_nxt.intLevel = 1'b0;
      // R13 drive low while any cause is pending
      q_nxt.intDrive = q_nxt.resetDonePending || q_nxt.faultPending;
      // R12 module ties presence low
      q_nxt.presenceN = 1'b0;
      q_nxt.highPower = (q_nxt.state == ST_HIGH_POWER);
      q_nxt.lowPower = (q_nxt.state != ST_HIGH_POWER);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         q_r <= '0;
         q_r.state <= ST_RESET;
         // R7 undriven init mode seen as software control
         q_r.initSync1 <= 1'b1;
         q_r.initSync2 <= 1'b1;
         q_r.swControl <= 1'b1;
         q_r.selSync1 <= 1'b1;
         q_r.selSync2 <= 1'b1;
         q_r.dataNotReady <= 1'b1;
         q_r.lowPower <= 1'b1;
         q_r.rstCount <= '0;
         q_r.lastCmd <= `RESET_CMD_VALUE;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign presenceDetectN = q_r.presenceN;
   assign interruptOutNOut = q_r.intLevel;
   assign interruptOutNOe = q_r.intDrive;
   assign highPowerMode = q_r.highPower;
   assign lowPowerMode = q_r.lowPower;
   assign dataNotReady = q_r.dataNotReady;
   assign swInitControl = q_r.swControl;
   assign resetDoneFlag = q_r.resetDonePending;
   assign faultFlag = q_r.faultPending;
   assign lastCommand = q_r.lastCmd;
endmodule

// file: sideband_sva.sv
// Port checker of the sideband control block
`include "sideband_defines.svh"
module sideband_sva #(
   parameter int RESET_MIN_CYC = `RESET_MIN_CYC,
   parameter int MGMT_INIT_CYC = `MGMT_INIT_CYC
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic sclClk,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic moduleSelectN,
   input wire logic moduleResetN,
   input wire logic initControlSelect,
   input wire logic faultIn,
   input wire logic presenceDetectN,
   input wire logic interruptOutNOut,
   input wire logic interruptOutNOe,
   input wire logic highPowerMode,
   input wire logic lowPowerMode,
   input wire logic dataNotReady,
   input wire logic swInitControl,
   input wire logic resetDoneFlag,
   input wire logic faultFlag,
   input sideband_pkg::mgmt_byte_t lastCommand
);
   timeunit 1ns;
   timeprecision 100ps;
   import sideband_pkg::*;
   logic [7:0] lowCnt_r;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // Saturating count of raw reset-pin low cycles
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) lowCnt_r <= 8'h00;
      else lowCnt_r <= moduleResetN ? 8'h00 : lowCnt_r + 8'(lowCnt_r != 8'hff);
   end
   a_open_drain: assert property (!interruptOutNOut && !sdaOut)
      else $error("driven output not low");
   a_present_low: assert property (!presenceDetectN)
      else $error("presence not low");
   a_power_inverse: assert property (highPowerMode != lowPowerMode)
      else $error("power modes not inverse");
   a_int_on_flag: assert property ((resetDoneFlag || faultFlag) |-> ##[0:1] interruptOutNOe)
      else $error("interrupt missing");
   a_done_ready: assert property ($rose(resetDoneFlag) |-> !dataNotReady)
      else $error("done while not ready");
   a_sw_low: assert property ($rose(highPowerMode) && swInitControl |->
      lastCommand == `CMD_HIGH_POWER)
      else $error("high power without command");
   a_hw_high: assert property ($fell(dataNotReady) && !swInitControl |-> ##[0:2] highPowerMode)
      else $error("hardware mode not high");
   a_long_reset: assert property (lowCnt_r == 8'(RESET_MIN_CYC + 6) |->
      dataNotReady && !highPowerMode && !faultFlag && lastCommand == 8'h00)
      else $error("long reset ignored");
   a_short_pulse: assert property (!dataNotReady && moduleResetN ##1 !moduleResetN [*2]
      ##1 moduleResetN |-> !dataNotReady [*8])
      else $error("short pulse reset");
   a_sel_block: assert property ((moduleSelectN && moduleResetN) [*8] |=> $stable(lastCommand))
      else $error("command while deselected");
   c_done: cover property ($rose(resetDoneFlag));
   c_high: cover property ($rose(highPowerMode));
   c_fault: cover property ($rose(faultFlag));
endmodule
bind module_sideband_control sideband_sva #(.RESET_MIN_CYC(RESET_MIN_CYC),
   .MGMT_INIT_CYC(MGMT_INIT_CYC)) chk (.*);

// file: host_model.sv
// Host board controller model for the two-wire link
module host_model (
   output logic sclClk,
   output logic hostSdaLow,
   output logic moduleSelectN,
   input wire logic sdaIn
);
   timeunit 1ns;
   timeprecision 100ps;
   import sideband_pkg::*;
   initial begin
      sclClk = 1'b0;
      hostSdaLow = 1'b0;
      moduleSelectN = 1'b1;
   end
   task automatic sendByte(input mgmt_byte_t b, input logic selN, output logic ack);
      moduleSelectN = selN;
      #6;
      for (int i = 7; i >= 0; i--) begin
         hostSdaLow = !b[i];
         #6 sclClk = 1'b1;
         #6 sclClk = 1'b0;
      end
      hostSdaLow = 1'b0;
      #5 ack = !sdaIn;
      #1 sclClk = 1'b1;
      #6 sclClk = 1'b0;
      // Select held until the command lands
      #60 moduleSelectN = 1'b1;
   endtask
endmodule

// file: tb_top.sv
// Testbench of the sideband control block
`include "sideband_defines.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import sideband_pkg::*;
   logic clk, resetn, moduleResetN, initEn, initVal, faultIn;
   logic sdaOut, sdaOe, presenceDetectN, interruptOutNOut, interruptOutNOe;
   logic highPowerMode, lowPowerMode, dataNotReady, swInitControl, resetDoneFlag, faultFlag;
   mgmt_byte_t lastCommand;
   wire sclClk, moduleSelectN, hostSdaLow, sdaIn, initControlSelect, intLine;
   int errorCnt = 0;
   int checked = 0;
   assign sdaIn = !(hostSdaLow || (sdaOe && !sdaOut));
   assign intLine = interruptOutNOe ? interruptOutNOut : 1'b1;
   assign initControlSelect = initEn ? initVal : 1'bz;
   pullup (initControlSelect);
   module_sideband_control #(.RESET_MIN_CYC(4), .MGMT_INIT_CYC(8)) uut (.*);
   host_model host (.*);
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, errorCnt);
      if (errorCnt == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         errorCnt++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic waitReady();
      for (int i = 0; i < 60 && dataNotReady !== 1'b0; i++)
         @(negedge clk);
      // Limit reached counts as a mismatch
      chk(dataNotReady, 1'b0);
      cyc(2);
   endtask
   task automatic cmd(input mgmt_byte_t b, input logic selN, input logic expAck);
      logic ack;
      host.sendByte(b, selN, ack);
      chk(8'(ack), 8'(expAck));
      cyc(12);
   endtask
   task automatic t_powerup();
      chk(dataNotReady, 1'b1);
      chk(intLine, 1'b1);
      waitReady();
      chk(intLine, 1'b0);
      chk(resetDoneFlag, 1'b1);
      chk(swInitControl, 1'b1);
      chk(lowPowerMode, 1'b1);
      chk(presenceDetectN, 1'b0);
      $display("powerup done");
   endtask
   task automatic t_cmds();
      cmd(`CMD_CLEAR_INT, 1'b0, 1'b1);
      chk(intLine, 1'b1);
      cmd(`CMD_HIGH_POWER, 1'b1, 1'b0);
      chk(highPowerMode, 1'b0);
      cmd(`CMD_HIGH_POWER, 1'b0, 1'b1);
      chk(highPowerMode, 1'b1);
      chk(lastCommand, `CMD_HIGH_POWER);
      faultIn = 1'b1;
      cyc(1);
      faultIn = 1'b0;
      cyc(3);
      chk(faultFlag, 1'b1);
      chk(intLine, 1'b0);
      cmd(`CMD_LOW_POWER, 1'b0, 1'b1);
      chk(lowPowerMode, 1'b1);
      cmd(`CMD_HIGH_POWER, 1'b0, 1'b1);
      $display("commands done");
   endtask
   task automatic t_resets();
      moduleResetN = 1'b0;
      cyc(2);
      moduleResetN = 1'b1;
      cyc(10);
      chk(dataNotReady, 1'b0);
      chk(highPowerMode, 1'b1);
      chk(faultFlag, 1'b1);
      moduleResetN = 1'b0;
      cyc(12);
      chk(dataNotReady, 1'b1);
      chk(highPowerMode, 1'b0);
      chk(faultFlag, 1'b0);
      chk(lastCommand, 8'h00);
      moduleResetN = 1'b1;
      waitReady();
      chk(intLine, 1'b0);
      $display("resets done");
   endtask
   task automatic t_hwmode();
      resetn = 1'b0;
      initEn = 1'b1;
      initVal = 1'b0;
      cyc(8);
      resetn = 1'b1;
      waitReady();
      chk(swInitControl, 1'b0);
      chk(highPowerMode, 1'b1);
      cmd(`CMD_LOW_POWER, 1'b0, 1'b1);
      chk(highPowerMode, 1'b1);
      $display("hardware mode done");
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = !clk;
   end
   initial begin
      resetn = 1'b0;
      moduleResetN = 1'b1;
      initEn = 1'b0;
      initVal = 1'b1;
      faultIn = 1'b0;
      cyc(8);
      resetn = 1'b1;
      t_powerup();
      t_cmds();
      t_resets();
      t_hwmode();
      finish_test();
   end
   initial begin
      #50000;
      errorCnt++;
      finish_test();
   end
endmodule
